// ===== bench/dfd_host_model.sv
// Host model: Avalon-MM master for the register bank.
// Assumes one clock; each access starts after the next rising edge.
`timescale 1ns/1ps
module dfd_host_model (
  input wire logic clk_i,
  input wire logic wait_i,
  input wire logic [31:0] rdata_i,
  output logic [7:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [31:0] wdata_o,
  output logic [3:0] be_o
);
  initial begin
    addr_o = 8'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 32'h0;
    be_o = 4'h0;
  end
  // ==========================================================
  // Bus access
  // host clears by zero, disables before writing
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b,
                      output logic [31:0] q);
    @(posedge clk_i);
    rd_o <= ~w;
    wr_o <= w;
    addr_o <= a;
    wdata_o <= d;
    be_o <= b;
    @(posedge clk_i);
    while (wait_i !== 1'b0) @(posedge clk_i);
    q = rdata_i;
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    // Released address and data lines show junk, not the last value; byte enables keep theirs
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
endmodule

// ===== bench/tb_top.sv
// Testbench: scenarios for the fault and diagnosis register bank.
// Assumes one wait state per access and the host model as master.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD %0t got %h want %h", $time, a, e); end end
module tb_top;
  import dfd_pkg::*;
  // Arbitrary version value
  localparam logic [15:0] FW_WORD = 16'h0215;
  logic clk, rst, rd, wr, den, alarm_pin, ares, flt, wt;
  logic [7:0] addr;
  logic [31:0] wd, rdat, q;
  logic [3:0] be;
  logic [15:0] fo, af, q16;
  dfd_fault_evt_t ev;
  int n_fail = 0;
  int checks = 0;
  dfd_regs #(.FW_VERSION(FW_WORD)) dut (.CLOCK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wt), .FAULT_EVENT_I(ev), .DRIVE_ENABLE_I(den), .ALARM_RESET_INPUT_I(alarm_pin),
    .ALARM_RESET_O(ares), .FAULTED_O(flt), .FORCED_OUTPUT_CONTROL_O(fo), .ADJUSTMENT_FUNCTION_O(af));
  dfd_host_model host (.clk_i(clk), .wait_i(wt), .rdata_i(rdat), .addr_o(addr), .rd_o(rd), .wr_o(wr),
    .wdata_o(wd), .be_o(be));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ==========================================================
  // Helpers
  function automatic logic [15:0] bcd(input int n);
    return {4'(n / 1000 % 10), 4'(n / 100 % 10), 4'(n / 10 % 10), 4'(n % 10)};
  endfunction
  task automatic rreg(input logic [5:0] i, output logic [15:0] v);
    host.xfer(1'b0, {i, 2'b00}, 32'h0, 4'hf, q);
    `CHK(q[31:16], 16'h0000)
    v = q[15:0];
  endtask
  task automatic wreg(input logic [5:0] i, input logic [15:0] v, input logic [3:0] b);
    host.xfer(1'b1, {i, 2'b00}, {16'h0000, v}, b, q);
  endtask
  task automatic pulse_fault(input logic [15:0] c);
    @(posedge clk);
    ev <= '{valid: 1'b1, code: c};
    @(posedge clk);
    ev <= '0;
    @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset_values;
    rreg(IDX_FW_VERSION, q16);
    `CHK(q16, FW_WORD)
    wreg(IDX_FW_VERSION, 16'h1111, 4'hf);
    rreg(IDX_FW_VERSION, q16);
    `CHK(q16, FW_WORD)
    for (int k = 0; k < HIST_DEPTH; k++) begin
      rreg(IDX_HIST_BASE + 6'(k), q16);
      `CHK(q16, HIST_RST)
    end
    rreg(6'h3f, q16);
    `CHK(q16, 16'h0000)
    `CHK(fo, FORCED_OUT_RST)
  endtask
  task automatic t_faults;
    int codes[6] = '{11, 23, 48, 67, 99, 7};
    foreach (codes[k]) begin
      pulse_fault(16'(codes[k]));
      `CHK(flt, 1'b1)
      rreg(IDX_FAULT_CODE, q16);
      `CHK(q16, bcd(codes[k]))
    end
    for (int k = 0; k < HIST_DEPTH; k++) begin
      rreg(IDX_HIST_BASE + 6'(k), q16);
      `CHK(q16, 16'(codes[5 - k]))
    end
    rreg(IDX_STATUS, q16);
    `CHK(q16[STS_FAULTED_BIT], 1'b1)
  endtask
  task automatic t_clear;
    int k;
    wreg(IDX_FAULT_CODE, 16'h0005, 4'h3);
    #1;
    `CHK(ares, 1'b0)
    rreg(IDX_FAULT_CODE, q16);
    `CHK(q16, bcd(7))
    `CHK(flt, 1'b1)
    wreg(IDX_FAULT_CODE, 16'h0000, 4'h3);
    #1;
    `CHK(ares, 1'b1)
    `CHK(flt, 1'b0)
    rreg(IDX_FAULT_CODE, q16);
    `CHK(q16, 16'h0000)
    pulse_fault(16'd2);
    alarm_pin <= 1'b1;
    k = 0;
    while (ares !== 1'b1 && k < 12) begin
      @(posedge clk);
      k++;
    end
    `CHK(ares, 1'b1)
    `CHK(flt, 1'b0)
    alarm_pin <= 1'b0;
  endtask
  task automatic t_protect;
    @(posedge clk);
    den <= 1'b1;
    wreg(IDX_FORCED_OUT, 16'h00a5, 4'hf);
    wreg(IDX_ADJUST, 16'h005a, 4'hf);
    #1;
    `CHK(fo, FORCED_OUT_RST)
    `CHK(af, ADJUST_RST)
    rreg(IDX_STATUS, q16);
    `CHK(q16[2:1], 2'b11)
    wreg(IDX_STATUS, 16'h0004, 4'hf);
    @(posedge clk);
    den <= 1'b0;
    wreg(IDX_FORCED_OUT, 16'h00a5, 4'hf);
    wreg(IDX_ADJUST, 16'h1234, 4'h1);
    #1;
    `CHK(fo, 16'h00a5)
    `CHK(af, 16'h0034)
    rreg(IDX_STATUS, q16);
    `CHK(q16[2:0], 3'b000)
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(fo, FORCED_OUT_RST)
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    rst = 1'b1;
    den = 1'b0;
    alarm_pin = 1'b0;
    ev = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset_values;
    t_faults;
    t_clear;
    t_protect;
    report_and_stop;
  end
  initial begin
    #400000;
    n_fail++;
    report_and_stop;
  end
endmodule

// ===== design/dfd_bcd_conv.sv
// Binary to packed BCD converter, four decimal digits.
// Purely combinational; values above 9999 show their low four digits.
`timescale 1ns/1ps
module dfd_bcd_conv (
  input wire logic [15:0] bin_i,
  output logic [15:0] bcd_o
);
  // ==========================================================
  // Shift-and-add-three
  always_comb begin
    logic [19:0] acc;
    acc = 20'h00000;
    for (int i = 15; i >= 0; i--) begin
      for (int d = 0; d < 5; d++) begin
        if (acc[d*4 +: 4] > 4'h4) begin
          acc[d*4 +: 4] = acc[d*4 +: 4] + 4'h3;
        end
      end
      acc = {acc[18:0], bin_i[i]};
    end
    bcd_o = acc[15:0];
  end
endmodule

// ===== design/dfd_pkg.sv
// Package for the drive fault and diagnosis register bank.
// Assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus.
package dfd_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_FW_VERSION = 6'h00;
  localparam logic [5:0] IDX_FAULT_CODE = 6'h02;
  localparam logic [5:0] IDX_HIST_BASE = 6'h10;
  localparam logic [5:0] IDX_FORCED_OUT = 6'h20;
  localparam logic [5:0] IDX_ADJUST = 6'h21;
  localparam logic [5:0] IDX_STATUS = 6'h22;

  // ==========================================================
  // Layout and reset values
  localparam int HIST_DEPTH = 5;
  localparam int WORD_W = 16;
  localparam logic [15:0] FORCED_OUT_RST = 16'h0000;
  localparam logic [15:0] ADJUST_RST = 16'h0000;
  localparam logic [15:0] HIST_RST = 16'h0000;
  localparam logic [15:0] FAULT_RST = 16'h0000;
  localparam int STS_FAULTED_BIT = 0;
  localparam int STS_ENABLED_BIT = 1;
  localparam int STS_REFUSED_BIT = 2;
  // Arbitrary neutral version value
  localparam logic [15:0] FW_VERSION_DFLT = 16'h0001;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic [15:0] code;
  } dfd_fault_evt_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } dfd_bus_state_t;

endpackage

// ===== design/dfd_regs.sv
// Drive fault and diagnosis register bank, Avalon-MM slave.
// Assumes fault events and drive enable come from logic on CLOCK_I;
// the alarm reset pin is asynchronous and is synchronised here.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module dfd_regs #(
  parameter logic [15:0] FW_VERSION = dfd_pkg::FW_VERSION_DFLT
) (
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire dfd_pkg::dfd_fault_evt_t FAULT_EVENT_I,
  input wire logic DRIVE_ENABLE_I,
  input wire logic ALARM_RESET_INPUT_I,
  output logic ALARM_RESET_O,
  output logic FAULTED_O,
  output logic [15:0] FORCED_OUTPUT_CONTROL_O,
  output logic [15:0] ADJUSTMENT_FUNCTION_O
);
  import dfd_pkg::*;

  // ==========================================================
  // Bus handshake: one wait state, so read data is registered
  dfd_bus_state_t bus_reg, bus_next;
  wire req = AVS_READ_I | AVS_WRITE_I;
  wire [5:0] idx = AVS_ADDRESS_I[7:2];
  assign bus_next = (req && bus_reg == BUS_IDLE) ? BUS_ACK : BUS_IDLE;
  assign AVS_WAITREQUEST_O = req && (bus_reg == BUS_IDLE);
  wire wr_fire = AVS_WRITE_I && (bus_reg == BUS_ACK);
  wire lo_full = AVS_BYTEENABLE_I[1:0] == 2'b11;

  // ==========================================================
  // Alarm reset pin: three stages, change once stages two and three agree
  logic ar_s1_reg, ar_s2_reg, ar_s3_reg, ar_lvl_reg, ar_lvl_d_reg;
  wire ar_lvl_next = (ar_s2_reg == ar_s3_reg) ? ar_s3_reg : ar_lvl_reg;
  wire ar_pin_rise = ar_lvl_reg && !ar_lvl_d_reg;

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      {ar_s1_reg, ar_s2_reg, ar_s3_reg, ar_lvl_reg, ar_lvl_d_reg} <= 5'h00;
    end else begin
      ar_s1_reg <= ALARM_RESET_INPUT_I;
      ar_s2_reg <= ar_s1_reg;
      ar_s3_reg <= ar_s2_reg;
      ar_lvl_reg <= ar_lvl_next;
      ar_lvl_d_reg <= ar_lvl_reg;
    end
  end

  // ==========================================================
  // Fault word and history
  logic faulted_reg;
  logic [15:0] fault_code_reg;
  logic [15:0] hist_reg [HIST_DEPTH];
  wire fault_wr = wr_fire && idx == IDX_FAULT_CODE && lo_full;
  wire clear_by_bus = fault_wr && AVS_WRITEDATA_I[15:0] == 16'h0000;
  wire clear_req = clear_by_bus || ar_pin_rise;

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      faulted_reg <= 1'b0;
      fault_code_reg <= FAULT_RST;
      ALARM_RESET_O <= 1'b0;
    end else begin
      ALARM_RESET_O <= clear_req;
      if (FAULT_EVENT_I.valid) begin
        faulted_reg <= 1'b1;
        fault_code_reg <= FAULT_EVENT_I.code;
      end else if (clear_req) begin
        // clear like alarm reset; new fault wins
        faulted_reg <= 1'b0;
        fault_code_reg <= FAULT_RST;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist_reg[i] <= HIST_RST;
      end
    end else if (FAULT_EVENT_I.valid) begin
      hist_reg[0] <= FAULT_EVENT_I.code;
      for (int i = 1; i < HIST_DEPTH; i++) begin
        hist_reg[i] <= hist_reg[i-1];
      end
    end
  end

  // ==========================================================
  // Protected parameters
  logic [15:0] forced_reg, adjust_reg;
  logic refused_reg;
  wire prot_hit = wr_fire && (idx == IDX_FORCED_OUT || idx == IDX_ADJUST);
  wire prot_ok = prot_hit && !DRIVE_ENABLE_I;
  wire refuse_set = prot_hit && DRIVE_ENABLE_I;
  wire refuse_clr = wr_fire && idx == IDX_STATUS && AVS_BYTEENABLE_I[0] &&
                    AVS_WRITEDATA_I[STS_REFUSED_BIT];

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      forced_reg <= FORCED_OUT_RST;
      adjust_reg <= ADJUST_RST;
      refused_reg <= 1'b0;
    end else begin
      if (prot_ok && idx == IDX_FORCED_OUT) begin
        forced_reg <= merge16(forced_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      end
      if (prot_ok && idx == IDX_ADJUST) begin
        adjust_reg <= merge16(adjust_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      end
      // Set wins over clear
      refused_reg <= refuse_set || (refused_reg && !refuse_clr);
    end
  end

  // ==========================================================
  // Read path
  logic [15:0] fault_bcd;
  dfd_bcd_conv u_bcd (
    .bin_i(fault_code_reg),
    .bcd_o(fault_bcd)
  );

  wire hist_sel = idx >= IDX_HIST_BASE && idx < IDX_HIST_BASE + 6'(HIST_DEPTH);
  wire [2:0] hist_idx = 3'(idx - IDX_HIST_BASE);
  wire [15:0] status_word = {13'h0, refused_reg, DRIVE_ENABLE_I, faulted_reg};
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (idx == IDX_FW_VERSION) rd_mux = FW_VERSION;
    else if (idx == IDX_FAULT_CODE) rd_mux = fault_bcd;
    else if (hist_sel) rd_mux = hist_reg[hist_idx];
    else if (idx == IDX_FORCED_OUT) rd_mux = forced_reg;
    else if (idx == IDX_ADJUST) rd_mux = adjust_reg;
    else if (idx == IDX_STATUS) rd_mux = status_word;
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      bus_reg <= BUS_IDLE;
      AVS_READDATA_O <= 32'h00000000;
    end else begin
      bus_reg <= bus_next;
      if (AVS_READ_I && bus_reg == BUS_IDLE) AVS_READDATA_O <= {16'h0000, rd_mux};
    end
  end

  assign FAULTED_O = faulted_reg;
  assign FORCED_OUTPUT_CONTROL_O = forced_reg;
  assign ADJUSTMENT_FUNCTION_O = adjust_reg;

  // ==========================================================
  // Checks
  sequence s_req_wait;
    req && bus_reg == BUS_IDLE && AVS_WAITREQUEST_O;
  endsequence
  sequence s_req_done;
    !AVS_WAITREQUEST_O && bus_reg == BUS_ACK;
  endsequence
  property p_bus_one_wait;
    @(posedge CLOCK_I) disable iff (RESET_I) s_req_wait ##1 req |-> s_req_done;
  endproperty
  a_bus_one_wait: assert property (p_bus_one_wait) else $error("bus answer not after one wait");
  property p_fault_shown;
    @(posedge CLOCK_I) disable iff (RESET_I)
      FAULT_EVENT_I.valid |=> faulted_reg && fault_code_reg == $past(FAULT_EVENT_I.code);
  endproperty
  a_fault_shown: assert property (p_fault_shown) else $error("fault not latched");
  property p_bcd_read;
    @(posedge CLOCK_I) disable iff (RESET_I)
      AVS_READ_I && bus_reg == BUS_IDLE && idx == IDX_FAULT_CODE && fault_code_reg == 16'h0017
      |=> AVS_READDATA_O[15:0] == 16'h0023;
  endproperty
  a_bcd_read: assert property (p_bcd_read) else $error("fault code not shown in BCD");
  property p_zero_clears;
    @(posedge CLOCK_I) disable iff (RESET_I)
      clear_by_bus && !FAULT_EVENT_I.valid |=> !faulted_reg && fault_code_reg == 16'h0000 && ALARM_RESET_O;
  endproperty
  a_zero_clears: assert property (p_zero_clears) else $error("zero write did not clear");
  property p_fw_read;
    @(posedge CLOCK_I) disable iff (RESET_I)
      AVS_READ_I && bus_reg == BUS_IDLE && idx == IDX_FW_VERSION |=> AVS_READDATA_O == {16'h0000, FW_VERSION};
  endproperty
  a_fw_read: assert property (p_fw_read) else $error("version word wrong");
  property p_hist_shift;
    @(posedge CLOCK_I) disable iff (RESET_I)
      FAULT_EVENT_I.valid |=> hist_reg[0] == $past(FAULT_EVENT_I.code) && hist_reg[4] == $past(hist_reg[3]);
  endproperty
  a_hist_shift: assert property (p_hist_shift) else $error("history did not shift");
  property p_protect;
    @(posedge CLOCK_I) disable iff (RESET_I)
      prot_hit && DRIVE_ENABLE_I |=> $stable(forced_reg) && $stable(adjust_reg) && refused_reg;
  endproperty
  a_protect: assert property (p_protect) else $error("protected write accepted while enabled");
  property p_forced_default;
    @(posedge CLOCK_I) disable iff (RESET_I) $fell(RESET_I) |-> forced_reg == 16'h0000;
  endproperty
  a_forced_default: assert property (p_forced_default) else $error("forced output not zero");
  property p_nonzero_ignored;
    @(posedge CLOCK_I) disable iff (RESET_I)
      fault_wr && AVS_WRITEDATA_I[15:0] != 16'h0000 && !FAULT_EVENT_I.valid && !ar_pin_rise
      |=> $stable(fault_code_reg) && $stable(faulted_reg) && $stable(hist_reg[0]);
  endproperty
  a_nonzero_ignored: assert property (p_nonzero_ignored) else $error("non-zero write changed fault");
endmodule
